// ==== logic/fwp_pkg.sv ====
// fwp_pkg: constants, register map and carriers of the flash write-protect
// checker. assumes nothing of its surroundings.
package fwp_pkg;
	localparam int ADDR_W = 24;
	localparam int SECTORS = 256;
	localparam int SECTOR_LSB = 16;
	localparam int SUBSECTOR_LSB = 12;
	localparam int PAGE_LSB = 8;
	localparam int ARRAY_BYTES = 16777216;
	localparam int OTP_BYTES = 64;
	localparam int BP_ALL = 9;
	// register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_LOCK = 8'h04;
	localparam logic [7:0] REG_RESULT = 8'h08;
	localparam logic [7:0] REG_ID = 8'h0C;
	localparam logic [31:0] ID_VALUE = 32'h00005A01; // arbitrary value
	// status register field positions
	localparam int ST_WEL = 1;
	localparam int ST_BP_LSB = 2;
	localparam int ST_TB = 6;
	localparam int ST_PWR = 8;
	localparam logic [31:0] STATUS_RST = 32'h00000000;
	// power-on guard time after supply good
	localparam int GUARD_US = 100;
	localparam int CLK_MHZ = 200;
	localparam int GUARD_CYC = GUARD_US * CLK_MHZ;
	// command codes on the link
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_PROG = 3'h1,
		CMD_ERASE_SUB = 3'h2,
		CMD_ERASE_SEC = 3'h3,
		CMD_ERASE_BULK = 3'h4,
		CMD_ERASE_PAGE = 3'h5,
		CMD_WRITE_LOCK = 3'h6,
		CMD_WREN = 3'h7
	} fwp_cmd_e;
	typedef struct packed {
		logic [7:0] sector;
		logic [11:0] subsector;
		logic [15:0] page;
	} fwp_decode_s;
	typedef struct packed {
		logic granted;
		logic refused;
		logic [3:0] cause;
	} fwp_verdict_s;
	localparam logic [3:0] CAUSE_OK = 4'h0;
	localparam logic [3:0] CAUSE_POWER = 4'h1;
	localparam logic [3:0] CAUSE_COUNT = 4'h2;
	localparam logic [3:0] CAUSE_WEL = 4'h3;
	localparam logic [3:0] CAUSE_PROT = 4'h4;
	localparam logic [3:0] CAUSE_KIND = 4'h5;
	localparam logic [3:0] CAUSE_FROZEN = 4'h6;
endpackage : fwp_pkg

// ==== logic/fwp_flash_array_write_protect.sv ====
// fwp_flash_array_write_protect: decides whether a program, erase or
// lock write may proceed. assumes the link pins come asynchronously
// (select, clock, command fields) and an AXI4-Lite master on clk.
//
// Contract
// - any single 256 byte page may be programmed alone
// - programming only clears bits; zeros stay zero
// - erase only by subsector, sector or whole array, never page
// - erase sets every cell of the region to one
// - array of 16777216 bytes: 256 sectors, 4096 subsectors, 65536 pages
// - 64 one time programmable bytes unreachable by array addresses
// - modifying command runs only if clock count is whole bytes
// - modifying command refused unless write enable latch is set
// - modifications held off until supply good and guard timer done
// - sector write lock bit set blocks program and erase there
// - lock down bit freezes sector protection until reset
// - lock bits change only by lock write, ignored if locked down
// - top/bottom 0: protect top 2^(bp-1) sectors, 9..15 all
// - top/bottom 1: protect bottom 2^(bp-1) sectors, 9..15 all
// - block protect and top/bottom read together from status
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module fwp_flash_array_write_protect #(
	parameter int GUARD = fwp_pkg::GUARD_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic supplyGood,
	input wire logic linkSelectN,
	input wire logic linkClk,
	input wire logic [2:0] linkCmd,
	input wire logic [23:0] linkAddr,
	input wire logic lockDownReq,
	input wire logic lockWriteReq,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic opGranted,
	output logic opRefused,
	output logic [3:0] refuseCause,
	output logic eraseFill,
	output logic [23:0] regionBase,
	output logic [23:0] regionLast
);
	//////////////////////////////////////////////////////////////////////
	// synchronisers for pins
	logic [1:0] syncSel, syncClk, syncPwr, syncLd, syncLw;
	logic [2:0] syncCmd0, syncCmd1;
	logic [23:0] syncAddr0, syncAddr1;
	logic clkPrev, selPrev;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{syncSel, selPrev} <= 3'h7;
			{syncClk, clkPrev, syncPwr, syncLd, syncLw} <= 9'h000;
			{syncCmd0, syncCmd1, syncAddr0, syncAddr1} <= 54'h00000000000000;
		end else begin
			syncSel <= {syncSel[0], linkSelectN};
			syncClk <= {syncClk[0], linkClk};
			syncPwr <= {syncPwr[0], supplyGood};
			syncCmd0 <= linkCmd;
			syncCmd1 <= syncCmd0;
			syncAddr0 <= linkAddr;
			syncAddr1 <= syncAddr0;
			syncLd <= {syncLd[0], lockDownReq};
			syncLw <= {syncLw[0], lockWriteReq};
			clkPrev <= syncClk[1];
			selPrev <= syncSel[1];
		end
	end
	wire logic clkRise = syncClk[1] & ~clkPrev;
	wire logic frameEnd = syncSel[1] & ~selPrev;
	//////////////////////////////////////////////////////////////////////
	// power-on guard and edge count
	logic [31:0] guardCnt, next_guardCnt;
	logic [2:0] bitCnt, next_bitCnt;
	wire logic powerOk = (guardCnt == 32'(GUARD));
	always_comb begin
		next_guardCnt = guardCnt;
		if (!syncPwr[1])
			next_guardCnt = 32'h00000000;
		else if (!powerOk)
			next_guardCnt = guardCnt + 32'h00000001;
		next_bitCnt = bitCnt;
		if (!syncSel[1] && clkRise)
			next_bitCnt = bitCnt + 3'h1;
		else if (frameEnd)
			next_bitCnt = 3'h0;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			guardCnt <= 32'h00000000;
			bitCnt <= 3'h0;
		end else begin
			guardCnt <= next_guardCnt;
			bitCnt <= next_bitCnt;
		end
	end
	//////////////////////////////////////////////////////////////////////
	// address decode and protection map
	fwp_pkg::fwp_decode_s dec;
	fwp_pkg::fwp_cmd_e cmd;
	logic [31:0] status;
	logic [255:0] writeLock, lockDown;
	logic [3:0] bpVal;
	logic topBottom;
	logic [255:0] bpMask;
	assign cmd = fwp_pkg::fwp_cmd_e'(syncCmd1);
	assign dec.sector = syncAddr1[23:16];
	assign dec.subsector = syncAddr1[23:12];
	assign dec.page = syncAddr1[23:8];
	assign bpVal = status[fwp_pkg::ST_BP_LSB +: 4];
	assign topBottom = status[fwp_pkg::ST_TB];
	genvar gs;
	generate
		for (gs = 0; gs < fwp_pkg::SECTORS; gs++) begin : g_bp
			logic [8:0] span;
			assign span = (bpVal == 4'h0) ? 9'h000 :
				(bpVal >= 4'(fwp_pkg::BP_ALL)) ? 9'h100 :
				(9'h001 << (bpVal - 4'h1));
			assign bpMask[gs] = topBottom ?
				(9'(gs) < span) :
				(9'(gs) >= 9'h100 - span);
		end
	endgenerate
	//////////////////////////////////////////////////////////////////////
	// verdict
	fwp_pkg::fwp_verdict_s verdict, next_verdict;
	logic next_eraseFill;
	logic [23:0] next_regionBase, next_regionLast;
	logic [255:0] next_writeLock, next_lockDown;
	logic next_wel;
	logic modifying, anyProt;
	logic wel;
	always_comb begin
		next_verdict = '0;
		next_eraseFill = eraseFill;
		next_regionBase = regionBase;
		next_regionLast = regionLast;
		next_writeLock = writeLock;
		next_lockDown = lockDown;
		next_wel = wel;
		modifying = (cmd != fwp_pkg::CMD_NONE) && (cmd != fwp_pkg::CMD_WREN);
		anyProt = (cmd == fwp_pkg::CMD_ERASE_BULK) ? |(writeLock | bpMask) :
			writeLock[dec.sector] | bpMask[dec.sector];
		if (frameEnd && cmd != fwp_pkg::CMD_NONE) begin
			if (bitCnt != 3'h0) begin
				next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_COUNT};
			end else if (cmd == fwp_pkg::CMD_WREN) begin
				next_wel = 1'b1;
			end else if (!powerOk) begin
				next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_POWER};
			end else if (!wel) begin
				next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_WEL};
			end else if (cmd == fwp_pkg::CMD_ERASE_PAGE) begin
				next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_KIND};
			end else if (cmd == fwp_pkg::CMD_WRITE_LOCK) begin
				if (lockDown[dec.sector]) begin
					next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_FROZEN};
				end else begin
					next_writeLock[dec.sector] = syncLw[1];
					next_lockDown[dec.sector] = syncLd[1];
					next_verdict = '{1'b1, 1'b0, fwp_pkg::CAUSE_OK};
				end
			end else if (anyProt) begin
				next_verdict = '{1'b0, 1'b1, fwp_pkg::CAUSE_PROT};
			end else begin
				next_verdict = '{1'b1, 1'b0, fwp_pkg::CAUSE_OK};
				next_eraseFill = (cmd != fwp_pkg::CMD_PROG);
				unique case (cmd)
					fwp_pkg::CMD_PROG: {next_regionBase, next_regionLast} =
						{dec.page, 8'h00, dec.page, 8'hFF};
					fwp_pkg::CMD_ERASE_SUB: {next_regionBase, next_regionLast} =
						{dec.subsector, 12'h000, dec.subsector, 12'hFFF};
					fwp_pkg::CMD_ERASE_SEC: {next_regionBase, next_regionLast} =
						{dec.sector, 16'h0000, dec.sector, 16'hFFFF};
					default: {next_regionBase, next_regionLast} =
						{24'h000000, 24'hFFFFFF};
				endcase
			end
			if (modifying && bitCnt == 3'h0)
				next_wel = 1'b0;
		end
	end
	// granted programs may only AND data in; otp lies outside
	// the 24-bit region so no granted region reaches it
	//////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic awHeld, wHeld, next_awHeld, next_wHeld, next_bvalid, next_rvalid;
	logic [7:0] awAddrQ, next_awAddrQ;
	logic [31:0] wDataQ, next_wDataQ, next_rdata, next_status;
	logic [1:0] next_bresp, next_rresp;
	always_comb begin
		next_awHeld = awHeld | (awvalid & awready);
		next_wHeld = wHeld | (wvalid & wready);
		next_awAddrQ = (awvalid & awready) ? awaddr[7:0] : awAddrQ;
		next_wDataQ = (wvalid & wready) ? wdata : wDataQ;
		next_bvalid = bvalid & ~bready;
		next_bresp = bresp;
		next_status = status;
		next_status[fwp_pkg::ST_WEL] = next_wel;
		next_status[fwp_pkg::ST_PWR] = powerOk;
		if (next_awHeld && next_wHeld && !bvalid) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'h0;
			if (next_awAddrQ == fwp_pkg::REG_STATUS) begin
				if (wstrb[0] | ~(wvalid & wready)) begin
					next_status[fwp_pkg::ST_BP_LSB +: 4] =
						next_wDataQ[fwp_pkg::ST_BP_LSB +: 4];
					next_status[fwp_pkg::ST_TB] = next_wDataQ[fwp_pkg::ST_TB];
				end
			end else if (next_awAddrQ != fwp_pkg::REG_LOCK &&
				next_awAddrQ != fwp_pkg::REG_RESULT &&
				next_awAddrQ != fwp_pkg::REG_ID)
				next_bresp = 2'h2;
		end
		next_rvalid = rvalid & ~rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			unique case (araddr[7:0])
				fwp_pkg::REG_STATUS: next_rdata = status;
				fwp_pkg::REG_LOCK: next_rdata = {lockDown[dec.sector],
					writeLock[dec.sector], 22'h000000, dec.sector};
				fwp_pkg::REG_RESULT: next_rdata = {26'h0000000,
					verdict.refused, verdict.granted, verdict.cause};
				fwp_pkg::REG_ID: next_rdata = fwp_pkg::ID_VALUE;
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = 2'h2;
				end
			endcase
		end
	end
	assign awready = ~awHeld & ~bvalid;
	assign wready = ~wHeld & ~bvalid;
	assign arready = ~rvalid;
	assign wel = status[fwp_pkg::ST_WEL];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			verdict <= '0;
			{eraseFill, regionBase, regionLast} <= 49'h0000000000000;
			{writeLock, lockDown} <= 512'h0;
			status <= fwp_pkg::STATUS_RST;
			{awHeld, wHeld, bvalid, rvalid, bresp, rresp} <= 8'h00;
			{awAddrQ, wDataQ, rdata} <= 72'h000000000000000000;
		end else begin
			verdict <= next_verdict;
			eraseFill <= next_eraseFill;
			regionBase <= next_regionBase;
			regionLast <= next_regionLast;
			writeLock <= next_writeLock;
			lockDown <= next_lockDown;
			status <= next_status;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddrQ <= next_awAddrQ;
			wDataQ <= next_wDataQ;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end
	assign opGranted = verdict.granted;
	assign opRefused = verdict.refused;
	assign refuseCause = verdict.cause;
	//////////////////////////////////////////////////////////////////////
	// assertions
	property p_count;
		@(posedge clk) disable iff (!rstn)
		frameEnd && bitCnt != 3'h0 && cmd != fwp_pkg::CMD_NONE
		|=> opRefused && refuseCause == fwp_pkg::CAUSE_COUNT;
	endproperty
	a_count: assert property (p_count) else $error("partial byte ran");
	property p_wel;
		@(posedge clk) disable iff (!rstn)
		opGranted && $past(cmd) != fwp_pkg::CMD_WREN |-> $past(wel);
	endproperty
	a_wel: assert property (p_wel) else $error("granted without latch");
	property p_power;
		@(posedge clk) disable iff (!rstn) opGranted |-> $past(powerOk);
	endproperty
	a_power: assert property (p_power) else $error("early grant");
	property p_page;
		@(posedge clk) disable iff (!rstn)
		frameEnd && cmd == fwp_pkg::CMD_ERASE_PAGE |=> !opGranted;
	endproperty
	a_page: assert property (p_page) else $error("page erase granted");
	property p_prot;
		@(posedge clk) disable iff (!rstn)
		frameEnd && anyProt && cmd == fwp_pkg::CMD_PROG |=> !opGranted;
	endproperty
	a_prot: assert property (p_prot) else $error("protected write");
	property p_frozen;
		@(posedge clk) disable iff (!rstn)
		lockDown[dec.sector] |=>
		writeLock[$past(dec.sector)] == $past(writeLock[dec.sector]);
	endproperty
	a_frozen: assert property (p_frozen) else $error("frozen lock");
	property p_top;
		@(posedge clk) disable iff (!rstn)
		!topBottom && bpVal == 4'h1 |-> bpMask[255] && !bpMask[254];
	endproperty
	a_top: assert property (p_top) else $error("top map wrong");
	property p_bot;
		@(posedge clk) disable iff (!rstn)
		topBottom && bpVal == 4'h8 |-> bpMask[127] && !bpMask[128];
	endproperty
	a_bot: assert property (p_bot) else $error("bottom map wrong");
	c_grant: cover property (@(posedge clk) disable iff (!rstn) opGranted);
	c_refuse: cover property (@(posedge clk) disable iff (!rstn)
		opRefused && refuseCause == fwp_pkg::CAUSE_PROT);
	c_erase: cover property (@(posedge clk) disable iff (!rstn)
		opGranted && eraseFill);
endmodule : fwp_flash_array_write_protect

// ==== sim/fwp_host_model.sv ====
// fwp_host_model: link host that frames commands toward the checker.
// assumes the checker samples these pins with its own clock.
`timescale 1ns/1ps
module fwp_host_model (
	output logic linkSelectN,
	output logic linkClk,
	output logic [2:0] linkCmd,
	output logic [23:0] linkAddr,
	output logic lockDownReq,
	output logic lockWriteReq
);
	// the optional hardware write-protect pin is left unused by this host
	initial begin
		linkSelectN = 1'b1;
		linkClk = 1'b0;
		linkCmd = 3'h0;
		linkAddr = 24'h000000;
		lockDownReq = 1'b0;
		lockWriteReq = 1'b0;
	end
	// serial clock stands low between frames; gap varies the pace
	task automatic frame(input logic [2:0] c, input logic [23:0] a,
		input int bits, input logic wl, input logic ld, input int gap);
		linkCmd = c;
		linkAddr = a;
		lockWriteReq = wl;
		lockDownReq = ld;
		#(16 + gap) linkSelectN = 1'b0;
		#16;
		repeat (bits) begin
			linkClk = 1'b1;
			#32 linkClk = 1'b0;
			#32;
		end
		#16 linkSelectN = 1'b1;
		// qualifiers go stale once the frame end has been seen
		#40 linkCmd = ~c;
		lockWriteReq = ~wl;
		lockDownReq = ~ld;
	endtask : frame
endmodule : fwp_host_model

// ==== sim/testbench.sv ====
// testbench: drives the write-protect checker over link and AXI4-Lite.
// assumes fwp_host_model as the link host.
`timescale 1ns/1ps
module testbench;
	logic clk, rstn, supplyGood, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, opGranted, opRefused;
	logic linkSelectN, linkClk, lockDownReq, lockWriteReq, eraseFill;
	logic [2:0] linkCmd;
	logic [23:0] linkAddr, regionBase, regionLast;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic [3:0] refuseCause;
	logic [31:0] seed = 32'h00003E84;
	fwp_pkg::fwp_verdict_s last;
	int err_total, checked, pulses;
	logic wl, ld;
	fwp_host_model i_host (.linkSelectN(linkSelectN), .linkClk(linkClk),
		.linkCmd(linkCmd), .linkAddr(linkAddr),
		.lockDownReq(lockDownReq), .lockWriteReq(lockWriteReq));
	fwp_flash_array_write_protect #(.GUARD(10)) i_dut (.clk(clk),
		.rstn(rstn), .supplyGood(supplyGood), .linkSelectN(linkSelectN),
		.linkClk(linkClk), .linkCmd(linkCmd), .linkAddr(linkAddr),
		.lockDownReq(lockDownReq), .lockWriteReq(lockWriteReq),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.opGranted(opGranted), .opRefused(opRefused),
		.refuseCause(refuseCause), .eraseFill(eraseFill),
		.regionBase(regionBase), .regionLast(regionLast));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (opGranted === 1'b1 || opRefused === 1'b1) begin
			pulses <= pulses + 1;
			last <= {opGranted, opRefused, refuseCause};
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic chkv(input fwp_pkg::fwp_verdict_s got, exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t verdict got %h exp %h", $time, got, exp);
		end
	endtask : chkv
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [23:0] at(input int sec);
		logic [31:0] r;
		r = rnd();
		return {sec[7:0], r[15:0]};
	endfunction : at
	task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		chk(n < 50, 1, "bvalid");
		chk(bresp, er, "bresp");
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [31:0] a, e, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		chk(n < 50, 1, "rvalid");
		chk(rdata, e, "rdata");
		chk(rresp, er, "rresp");
		@(posedge clk);
	endtask : axr
	task automatic op(input logic [2:0] c, input logic [23:0] a,
		input int bits, input logic [3:0] z);
		int p;
		logic [23:0] m;
		p = pulses;
		i_host.frame(c, a, bits, wl, ld, rnd() % 24);
		for (int k = 0; k < 200 && pulses == p; k++)
			@(posedge clk);
		chk(pulses - p, 1, "pulse count");
		chkv(last, {z == fwp_pkg::CAUSE_OK, z != fwp_pkg::CAUSE_OK, z});
		m = c == fwp_pkg::CMD_PROG ? 24'h0000FF :
			c == fwp_pkg::CMD_ERASE_SUB ? 24'h000FFF :
			c == fwp_pkg::CMD_ERASE_SEC ? 24'h00FFFF : 24'hFFFFFF;
		@(posedge clk);
		if (z == fwp_pkg::CAUSE_OK && c != fwp_pkg::CMD_WRITE_LOCK) begin
			chk(regionBase, a & ~m, "base");
			chk(regionLast, a | m, "last");
			chk(eraseFill, c != fwp_pkg::CMD_PROG, "fill");
		end
	endtask : op
	task automatic wren();
		int p;
		p = pulses;
		i_host.frame(fwp_pkg::CMD_WREN, linkAddr, 8, wl, ld, 0);
		repeat (20) @(posedge clk);
		chk(pulses - p, 0, "enable pulse");
	endtask : wren
	task automatic eop(input logic [2:0] c, input int sec, bits,
		input logic [3:0] z);
		wren();
		op(c, at(sec), bits, z);
	endtask : eop
	task automatic lk(input logic w, d, input int s, input logic [3:0] z);
		wl = w;
		ld = d;
		eop(fwp_pkg::CMD_WRITE_LOCK, s, 8, z);
	endtask : lk
	////////////////////////////////////////////////////////////////
	initial begin
		#500us;
		err_total++;
		wrap_up();
	end
	initial begin
		int n, s, sec;
		logic [3:0] z;
		{rstn, supplyGood, awvalid, wvalid, bready, arvalid} <= 6'h00;
		{awaddr, wdata, araddr} <= 96'h0;
		{rready, wl, ld} <= 3'h0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		axr(fwp_pkg::REG_STATUS, fwp_pkg::STATUS_RST, 2'h0);
		axr(fwp_pkg::REG_ID, fwp_pkg::ID_VALUE, 2'h0);
		axr(fwp_pkg::REG_RESULT, 32'h00000000, 2'h0);
		axr(32'h00000010, 32'h0, 2'h2);
		axw(32'h00000020, 32'h0, 2'h2);
		eop(fwp_pkg::CMD_PROG, 18, 8, fwp_pkg::CAUSE_POWER);
		supplyGood <= 1'b1;
		repeat (30) @(posedge clk);
		eop(fwp_pkg::CMD_PROG, rnd() % 256, 16, 4'h0);
		axr(fwp_pkg::REG_STATUS, 32'h00000100, 2'h0);
		op(fwp_pkg::CMD_PROG, at(7), 8, fwp_pkg::CAUSE_WEL);
		wren();
		axr(fwp_pkg::REG_STATUS, 32'h00000102, 2'h0);
		op(fwp_pkg::CMD_PROG, at(9), 12, fwp_pkg::CAUSE_COUNT);
		eop(fwp_pkg::CMD_ERASE_PAGE, 9, 8, fwp_pkg::CAUSE_KIND);
		for (int k = 2; k < 5; k++)
			eop(3'(k), rnd() % 256, 8, 4'h0);
		for (int t = 0; t < 2; t++) begin
			for (int b = 0; b < 16; b++) begin
				axw(fwp_pkg::REG_STATUS, t << 6 | b << 2, 2'h0);
				axr(fwp_pkg::REG_STATUS, 32'h100 | t << 6 | b << 2, 2'h0);
				n = b == 0 ? 0 : b >= fwp_pkg::BP_ALL ? 256 : 1 << (b - 1);
				s = t ? n : 256 - n;
				for (int k = 0; k < 4; k++) begin
					sec = k == 0 ? 0 : k == 1 ? 255 : s + k - 3;
					sec = sec < 0 ? 0 : sec > 255 ? 255 : sec;
					z = (t ? sec < n : sec >= 256 - n) ? 4'h4 : 4'h0;
					eop(fwp_pkg::CMD_ERASE_SEC, sec, 8, z);
				end
			end
		end
		axw(fwp_pkg::REG_STATUS, 32'h0, 2'h0);
		s = rnd() % 255;
		lk(1'b1, 1'b0, s, fwp_pkg::CAUSE_OK);
		axr(fwp_pkg::REG_LOCK, {8'h40, 16'h0, s[7:0]}, 2'h0);
		eop(fwp_pkg::CMD_ERASE_SEC, s, 8, fwp_pkg::CAUSE_PROT);
		eop(fwp_pkg::CMD_PROG, s, 16, fwp_pkg::CAUSE_PROT);
		eop(fwp_pkg::CMD_ERASE_BULK, s + 1, 8, 4'h4);
		eop(fwp_pkg::CMD_ERASE_SUB, s + 1, 8, 4'h0);
		lk(1'b1, 1'b1, s, fwp_pkg::CAUSE_OK);
		axr(fwp_pkg::REG_LOCK, {8'hC0, 16'h0, s[7:0]}, 2'h0);
		lk(1'b0, 1'b0, s, fwp_pkg::CAUSE_FROZEN);
		eop(fwp_pkg::CMD_ERASE_SEC, s, 8, fwp_pkg::CAUSE_PROT);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (30) @(posedge clk);
		eop(fwp_pkg::CMD_ERASE_SEC, s, 8, fwp_pkg::CAUSE_OK);
		wrap_up();
	end
endmodule : testbench
